// >>> mbp_bus_pins.v
// Purpose: Multiplexed address/data bus, high address port and quasi ports
// Assumes: Core requests bus cycles through a start strobe and holds them
// Notes:   Active-high reset pin combined with the active-low system reset
`timescale 1ns/1ps
`include "mbp_defines.vh"
module mbp_bus_pins (
  input  wire        I_REF_CLK,
  input  wire        I_RST_N,
  input  wire        I_RESET_PIN,
  input  wire        I_EXT_FETCH_SELECT,
  input  wire        I_CYC_START,
  input  wire        I_CYC_IS_DATA,
  input  wire        I_CYC_IS_WRITE,
  input  wire        I_CYC_USE_P2_LATCH,
  input  wire [15:0] I_CYC_ADDR,
  input  wire [7:0]  I_CYC_WDATA,
  input  wire        I_STRETCH_WR,
  input  wire [2:0]  I_STRETCH_DATA,
  input  wire        I_P1_WR,
  input  wire [7:0]  I_P1_WDATA,
  input  wire        I_P2_WR,
  input  wire [7:0]  I_P2_WDATA,
  input  wire        I_P3_WR,
  input  wire [7:0]  I_P3_WDATA,
  input  wire        I_SERIAL0_TRANSMIT_OUT,
  input  wire        I_TIMER2_EXT_IO_OUT,
  input  wire [7:0]  I_MUXED_LOW_ADDR_DATA,
  input  wire [7:0]  I_P1_PINS,
  input  wire [7:0]  I_P3_PINS,
  output reg  [7:0]  O_MUXED_LOW_ADDR_DATA,
  output reg         O_MUXED_LOW_ADDR_DATA_OE,
  output reg  [7:0]  O_HIGH_ADDR,
  output reg         O_ADDR_LATCH_PULSE,
  output reg         O_PROGRAM_FETCH_STROBE_N,
  output reg         O_CYC_DONE,
  output reg  [7:0]  O_CYC_RDATA,
  output reg         O_CYC_BUSY,
  output reg  [2:0]  O_STRETCH_SELECT,
  output reg  [7:0]  O_P1_PULL_DOWN,
  output reg  [7:0]  O_P1_STRONG_UP,
  output reg  [7:0]  O_P3_PULL_DOWN,
  output reg  [7:0]  O_P3_STRONG_UP,
  output reg  [7:0]  O_P1_IN,
  output reg  [7:0]  O_P3_IN,
  output reg  [3:0]  O_EXT_IRQ_EDGE,
  output reg         O_CONFIG_FAULT
);
  localparam ST_IDLE  = 3'b001;
  localparam ST_ADDR  = 3'b010;
  localparam ST_DATA  = 3'b100;

  reg  [2:0]  state_ff;
  reg  [2:0]  nxt_state;
  reg  [1:0]  phase_ff;
  reg  [3:0]  mc_cnt_ff;
  reg  [3:0]  mc_total_ff;
  reg         is_data_ff;
  reg         is_write_ff;
  reg  [15:0] addr_ff;
  reg  [7:0]  wdata_ff;
  reg  [2:0]  stretch_ff;
  reg         rd_n_ff;
  reg         wr_n_ff;

  wire        in_reset;
  wire [7:0]  p2_latch;
  wire [7:0]  p1_pd;
  wire [7:0]  p1_su;
  wire [7:0]  p3_pd;
  wire [7:0]  p3_su;
  wire [7:0]  p3_force;
  wire [7:0]  p1_force;
  wire [3:0]  irq_pulse;
  wire [3:0]  irq_level;
  wire        last_phase;
  wire        block_rst_n;

  // Pin idles low, so any wired-OR source asserting high holds reset
  assign in_reset    = I_RESET_PIN || !I_RST_N;                        // see (R01)
  assign block_rst_n = !in_reset;
  assign last_phase  = (phase_ff == (`MBP_CLKS_PER_MC - 3'h1));

  always @(posedge I_REF_CLK) begin
    if (in_reset) begin
      stretch_ff <= `MBP_STRETCH_RST;                                  // see (R25)
    end else if (I_STRETCH_WR) begin
      stretch_ff <= I_STRETCH_DATA;
    end
  end

  mbp_quasi_port #(.WIDTH(8)) u_p1 (
    .clk          (I_REF_CLK),
    .rst_n        (block_rst_n),
    .wr_en        (I_P1_WR),
    .wr_data      (I_P1_WDATA),
    .force_low    (p1_force),
    .latch_q      (),
    .pull_down_en (p1_pd),
    .strong_up_en (p1_su)
  );

  mbp_quasi_port #(.WIDTH(8)) u_p3 (
    .clk          (I_REF_CLK),
    .rst_n        (block_rst_n),
    .wr_en        (I_P3_WR),
    .wr_data      (I_P3_WDATA),
    .force_low    (p3_force),
    .latch_q      (),
    .pull_down_en (p3_pd),
    .strong_up_en (p3_su)
  );                                                                   // see (R11)

  // Port 2 latch kept only as a high-byte source for indirect moves
  mbp_quasi_port #(.WIDTH(8)) u_p2 (
    .clk          (I_REF_CLK),
    .rst_n        (block_rst_n),
    .wr_en        (I_P2_WR),
    .wr_data      (I_P2_WDATA),
    .force_low    (8'h00),
    .latch_q      (p2_latch),
    .pull_down_en (),
    .strong_up_en ()
  );

  // Timer 2 io pulls P1.0 low whenever its output is low, ORed with a low latch bit
  assign p1_force = {7'h00, !I_TIMER2_EXT_IO_OUT};                     // see (R16)
  assign p3_force = {!rd_n_ff, !wr_n_ff, 4'h0,
                     !I_SERIAL0_TRANSMIT_OUT, 1'b0};                   // see (R19) see (R21)

  assign irq_level = {I_P1_PINS[`MBP_BIT_IRQ5], I_P1_PINS[`MBP_BIT_IRQ4],
                      I_P1_PINS[`MBP_BIT_IRQ3], I_P1_PINS[`MBP_BIT_IRQ2]};

  mbp_edge_detect #(.WIDTH(4)) u_irq (
    .clk    (I_REF_CLK),
    .rst_n  (block_rst_n),
    .level  (irq_level),
    .rising (4'b0101),                                                 // see (R17) see (R18)
    .pulse  (irq_pulse)
  );

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (I_CYC_START) begin
          nxt_state = ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (phase_ff == 2'h1) begin
          nxt_state = ST_DATA;
        end
      end
      ST_DATA: begin
        if (last_phase && (mc_cnt_ff == mc_total_ff - 4'h1)) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge I_REF_CLK) begin
    if (in_reset) begin
      state_ff    <= ST_IDLE;
      phase_ff    <= 2'h0;
      mc_cnt_ff   <= 4'h0;
      mc_total_ff <= `MBP_MOVE_BASE_MC;
      is_data_ff  <= 1'b0;
      is_write_ff <= 1'b0;
      addr_ff     <= 16'h0000;
      wdata_ff    <= 8'h00;
      rd_n_ff     <= 1'b1;
      wr_n_ff     <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == ST_IDLE) begin
        phase_ff  <= 2'h0;
        mc_cnt_ff <= 4'h0;
        if (I_CYC_START) begin
          is_data_ff  <= I_CYC_IS_DATA;
          is_write_ff <= I_CYC_IS_WRITE;
          wdata_ff    <= I_CYC_WDATA;
          // Full 16-bit address in both spaces
          addr_ff     <= (I_CYC_IS_DATA && I_CYC_USE_P2_LATCH) ?
                         {p2_latch, I_CYC_ADDR[7:0]} : I_CYC_ADDR;     // see (R13) see (R14)
          // Fetch is one machine cycle; data move 2 + stretch
          mc_total_ff <= I_CYC_IS_DATA ? (`MBP_MOVE_BASE_MC + {1'b0, stretch_ff})
                                       : 4'h1;                         // see (R15) see (R24)
        end
      end else begin
        phase_ff <= phase_ff + 2'h1;                                   // see (R23)
        if (last_phase) begin
          mc_cnt_ff <= mc_cnt_ff + 4'h1;
        end
      end
      // Strobes span the data phase; stretch widens them only for data moves
      rd_n_ff <= !(nxt_state == ST_DATA && is_data_ff && !is_write_ff &&
                   !(last_phase && mc_cnt_ff == mc_total_ff - 4'h1));  // see (R25) see (R26)
      wr_n_ff <= !(nxt_state == ST_DATA && is_data_ff && is_write_ff &&
                   !(last_phase && mc_cnt_ff == mc_total_ff - 4'h1));  // see (R26)
    end
  end

  always @(posedge I_REF_CLK) begin
    if (in_reset) begin
      O_MUXED_LOW_ADDR_DATA    <= `MBP_PORT_RST;                       // see (R07)
      O_MUXED_LOW_ADDR_DATA_OE <= 1'b0;
      O_HIGH_ADDR              <= `MBP_PORT_RST;
      O_ADDR_LATCH_PULSE       <= 1'b1;                                // see (R04)
      O_PROGRAM_FETCH_STROBE_N <= 1'b1;                                // see (R03)
      O_CYC_DONE               <= 1'b0;
      O_CYC_RDATA              <= 8'h00;
      O_CYC_BUSY               <= 1'b0;
      O_CONFIG_FAULT           <= 1'b0;
    end else begin
      O_ADDR_LATCH_PULSE <= (nxt_state == ST_ADDR);                    // see (R23)
      if (nxt_state == ST_ADDR) begin
        O_MUXED_LOW_ADDR_DATA    <= (state_ff == ST_IDLE) ? I_CYC_ADDR[7:0] : addr_ff[7:0];
        O_MUXED_LOW_ADDR_DATA_OE <= 1'b1;                              // see (R05)
      end else if (nxt_state == ST_DATA) begin
        O_MUXED_LOW_ADDR_DATA    <= wdata_ff;
        O_MUXED_LOW_ADDR_DATA_OE <= is_data_ff && is_write_ff;         // see (R06)
      end else begin
        O_MUXED_LOW_ADDR_DATA    <= `MBP_PORT_RST;
        O_MUXED_LOW_ADDR_DATA_OE <= 1'b0;
      end
      if (state_ff == ST_IDLE && I_CYC_START) begin
        O_HIGH_ADDR <= (I_CYC_IS_DATA && I_CYC_USE_P2_LATCH) ? p2_latch : I_CYC_ADDR[15:8];
      end else begin
        O_HIGH_ADDR <= addr_ff[15:8];                                  // see (R12)
      end
      // Low only in data phase of a fetch, never for a data move
      O_PROGRAM_FETCH_STROBE_N <= !(nxt_state == ST_DATA && !is_data_ff); // see (R02) see (R03)
      O_CYC_BUSY  <= (nxt_state != ST_IDLE);
      O_CYC_DONE  <= (state_ff == ST_DATA) && (nxt_state == ST_IDLE);
      if (state_ff == ST_DATA && nxt_state == ST_IDLE && !is_write_ff) begin
        O_CYC_RDATA <= I_MUXED_LOW_ADDR_DATA;
      end
      // Board must ground this pin; flag it if not
      O_CONFIG_FAULT <= I_EXT_FETCH_SELECT;                            // see (R22)
    end
  end

  always @(posedge I_REF_CLK) begin
    if (in_reset) begin
      O_P1_PULL_DOWN   <= 8'h00;
      O_P1_STRONG_UP   <= 8'h00;
      O_P3_PULL_DOWN   <= 8'h00;
      O_P3_STRONG_UP   <= 8'h00;
      O_P1_IN          <= `MBP_PORT_RST;
      O_P3_IN          <= `MBP_PORT_RST;
      O_EXT_IRQ_EDGE   <= 4'h0;
      O_STRETCH_SELECT <= `MBP_STRETCH_RST;
    end else begin
      O_P1_PULL_DOWN   <= p1_pd;                                       // see (R09)
      O_P1_STRONG_UP   <= p1_su;                                       // see (R10)
      O_P3_PULL_DOWN   <= p3_pd;
      O_P3_STRONG_UP   <= p3_su;
      // Capture trigger, timer count and irq 0/1 pins are read here by the core
      O_P1_IN          <= I_P1_PINS;                                   // see (R16) see (R08)
      O_P3_IN          <= I_P3_PINS;                                   // see (R20)
      O_EXT_IRQ_EDGE   <= irq_pulse;                                   // see (R17) see (R18)
      O_STRETCH_SELECT <= stretch_ff;
    end
  end
endmodule // mbp_bus_pins

// >>> mbp_defines.vh
// Purpose: Constants for the multiplexed bus and port pin block
// Assumes: One clock, synchronous active-low reset, no register bus
// Notes:   Summary of the rules follows
// Summary of operation
// (R01) Reset pin is active high; idles low so sources may be wire-ORed.
// (R02) Program fetch strobe is active low, chip enable for external ROM.
// (R03) Program fetch strobe stays high during data moves and reset.
// (R04) Address latch pulse is forced high during reset.
// (R05) While latch pulse is high, port 0 drives the low address byte.
// (R06) After latch pulse falls, port 0 becomes the bidirectional data bus.
// (R07) Port 0 has no software latch and comes out of reset high.
// (R08) Port 1 resets to all ones under weak pullup, usable as input.
// (R09) Writing 0 to a port bit turns on strong pulldown until 1 or reset.
// (R10) Writing 1 over 0 pulses a strong pullup, then weak pullup remains.
// (R11) Port 3 resets high and behaves like port 1.
// (R12) Port 2 carries address bits 15..8 during external accesses.
// (R13) Port 2 latch never reaches pins; supplies high byte for indirect moves.
// (R14) 64 kB program space and separate 64 kB data space.
// (R15) Data move lasts two to nine machine cycles.
// (R16) P1.0 is timer 2 external io, P1.1 timer 2 capture trigger.
// (R17) P1.4 rising-edge interrupt 2, P1.5 falling-edge interrupt 3.
// (R18) P1.6 rising-edge interrupt 4, P1.7 falling-edge interrupt 5.
// (R19) P3.0 serial receive in, P3.1 serial transmit out.
// (R20) P3.2/P3.3 interrupts 0/1, P3.4/P3.5 timer 0/1 count inputs.
// (R21) P3.6 data write strobe, P3.7 data read strobe.
// (R22) Board ties the external fetch select input to ground.
// (R23) Machine cycle is four clocks with one latch pulse per cycle; code pulses it once per bus cycle, in the first machine cycle only.
// (R24) Stretch 0 gives two cycles, each step adds one, nine at 7.
// (R25) Stretch resets to 1; stretch widens strobes, not program fetches.
// (R26) Read and write strobes active low, never both asserted.
`ifndef MBP_DEFINES_VH
`define MBP_DEFINES_VH
`define MBP_CLKS_PER_MC   3'h4
`define MBP_STRETCH_RST   3'h1
`define MBP_MOVE_BASE_MC  4'h2
`define MBP_PORT_RST      8'hFF
`define MBP_BOOST_CLKS    2'h1
`define MBP_BIT_TMR2_IO   0
`define MBP_BIT_TMR2_TRIG 1
`define MBP_BIT_IRQ2      4
`define MBP_BIT_IRQ3      5
`define MBP_BIT_IRQ4      6
`define MBP_BIT_IRQ5      7
`define MBP_BIT_RX        0
`define MBP_BIT_TX        1
`define MBP_BIT_IRQ0      2
`define MBP_BIT_IRQ1      3
`define MBP_BIT_TMR0_CNT  4
`define MBP_BIT_TMR1_CNT  5
`define MBP_BIT_WR        6
`define MBP_BIT_RD        7
`endif

// >>> mbp_quasi_port.v
// Purpose: One quasi-bidirectional 8-bit port with per-bit drivers
// Assumes: Writes arrive as one-cycle strobes with a full byte
// Notes:   Pin level resolved outside from pulldown and pullup enables
`timescale 1ns/1ps
`include "mbp_defines.vh"
module mbp_quasi_port #(
  parameter WIDTH = 8
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             wr_en,
  input  wire [WIDTH-1:0] wr_data,
  input  wire [WIDTH-1:0] force_low,
  output wire [WIDTH-1:0] latch_q,
  output wire [WIDTH-1:0] pull_down_en,
  output wire [WIDTH-1:0] strong_up_en
);
  localparam [7:0] RST_BYTE = `MBP_PORT_RST;
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      // Per-bit registers keep each bit with a single driving process
      reg       latch_ff;
      reg [1:0] boost_cnt_ff;
      always @(posedge clk) begin
        if (!rst_n) begin
          latch_ff     <= RST_BYTE[g % 8];            // see (R08) see (R11)
          boost_cnt_ff <= 2'h0;
        end else begin
          if (wr_en) begin
            latch_ff <= wr_data[g];                   // see (R09)
          end
          if (wr_en && wr_data[g] && !latch_ff) begin
            boost_cnt_ff <= `MBP_BOOST_CLKS;          // see (R10)
          end else if (boost_cnt_ff != 2'h0) begin
            boost_cnt_ff <= boost_cnt_ff - 2'h1;
          end
        end
      end
      assign latch_q[g]      = latch_ff;
      // Alternate outputs (strobes, transmit) pull low through the same path
      assign pull_down_en[g] = !latch_ff || force_low[g];
      assign strong_up_en[g] = (boost_cnt_ff != 2'h0) && !pull_down_en[g];
    end
  endgenerate
endmodule // mbp_quasi_port

// >>> mbp_edge_detect.v
// Purpose: Edge capture for the port 1 interrupt pins
// Assumes: Inputs synchronous to the clock
// Notes:   Pulses last one clock
`timescale 1ns/1ps
module mbp_edge_detect #(
  parameter WIDTH = 4
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] level,
  input  wire [WIDTH-1:0] rising,
  output wire [WIDTH-1:0] pulse
);
  reg [WIDTH-1:0] prev_ff;
  always @(posedge clk) begin
    if (!rst_n) begin
      prev_ff <= {WIDTH{1'b1}};
    end else begin
      prev_ff <= level;
    end
  end
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_edge
      assign pulse[g] = rising[g] ? (level[g] && !prev_ff[g]) : (!level[g] && prev_ff[g]);
    end
  endgenerate
endmodule // mbp_edge_detect

// >>> mbp_bus_pins_properties.sv
// Purpose: Concurrent checks on the bus and pin block ports
// Assumes: Sync reset from I_RST_N low or I_RESET_PIN high
// Notes:   Bound into every mbp_bus_pins instance
`timescale 1ns/1ps
module mbp_bus_pins_chk (
  input wire        I_REF_CLK,
  input wire        I_RST_N,
  input wire        I_RESET_PIN,
  input wire        I_CYC_START,
  input wire        I_CYC_IS_DATA,
  input wire        I_CYC_USE_P2_LATCH,
  input wire [15:0] I_CYC_ADDR,
  input wire        I_P2_WR,
  input wire [7:0]  I_P2_WDATA,
  input wire        I_STRETCH_WR,
  input wire [2:0]  I_STRETCH_DATA,
  input wire [7:0]  I_P1_PINS,
  input wire [7:0]  O_MUXED_LOW_ADDR_DATA,
  input wire        O_MUXED_LOW_ADDR_DATA_OE,
  input wire [7:0]  O_HIGH_ADDR,
  input wire        O_ADDR_LATCH_PULSE,
  input wire        O_PROGRAM_FETCH_STROBE_N,
  input wire        O_CYC_BUSY,
  input wire [2:0]  O_STRETCH_SELECT,
  input wire [7:0]  O_P1_PULL_DOWN,
  input wire [7:0]  O_P1_STRONG_UP,
  input wire [7:0]  O_P3_PULL_DOWN,
  input wire [7:0]  O_P3_STRONG_UP,
  input wire [3:0]  O_EXT_IRQ_EDGE
);
  wire       rst = !I_RST_N || I_RESET_PIN;
  wire       acc = I_CYC_START && !O_CYC_BUSY;
  reg  [7:0] lo_ff;
  reg  [7:0] hi_ff;
  reg  [7:0] p2_ff;
  reg        dat_ff;
  reg  [5:0] len_ff;
  reg  [5:0] exp_ff;
  reg  [2:0] st_ff;
  always @(posedge I_REF_CLK) begin
    if (rst) begin
      p2_ff  <= 8'hFF;
      dat_ff <= 1'b0;
      len_ff <= 6'h00;
      st_ff  <= 3'h1;
    end else begin
      if (I_P2_WR)
        p2_ff <= I_P2_WDATA;
      if (I_STRETCH_WR)
        st_ff <= I_STRETCH_DATA;
      if (acc) begin
        lo_ff  <= I_CYC_ADDR[7:0];
        hi_ff  <= (I_CYC_IS_DATA && I_CYC_USE_P2_LATCH) ? p2_ff : I_CYC_ADDR[15:8];
        dat_ff <= I_CYC_IS_DATA;
        exp_ff <= I_CYC_IS_DATA ? {1'b0, st_ff, 2'b00} + 6'h08 : 6'h04;
        len_ff <= 6'h00;
      end else if (O_CYC_BUSY)
        len_ff <= len_ff + 6'h01;
    end
  end
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (rst);
  property p_rst_pins;
    disable iff (1'b0) rst |=> O_ADDR_LATCH_PULSE && O_PROGRAM_FETCH_STROBE_N && !O_MUXED_LOW_ADDR_DATA_OE
      && O_STRETCH_SELECT == 3'h1 && O_P1_PULL_DOWN == 8'h00 && O_P3_PULL_DOWN == 8'h00;
  endproperty
  a_rst_pins: assert property (p_rst_pins)
    else $error("reset state wrong");
  property p_ale_len;
    acc |-> ##1 O_ADDR_LATCH_PULSE [*2] ##1 !O_ADDR_LATCH_PULSE;
  endproperty
  a_ale_len: assert property (p_ale_len)
    else $error("latch pulse width");
  property p_ale_addr;
    O_ADDR_LATCH_PULSE && O_CYC_BUSY |-> O_MUXED_LOW_ADDR_DATA_OE && O_MUXED_LOW_ADDR_DATA == lo_ff;
  endproperty
  a_ale_addr: assert property (p_ale_addr)
    else $error("low address not on bus");
  property p_high_addr;
    O_CYC_BUSY |-> O_HIGH_ADDR == hi_ff;
  endproperty
  a_high_addr: assert property (p_high_addr)
    else $error("high address wrong");
  property p_fetch;
    acc && !I_CYC_IS_DATA |-> ##3 (!O_PROGRAM_FETCH_STROBE_N && !O_MUXED_LOW_ADDR_DATA_OE) [*2]
      ##1 O_PROGRAM_FETCH_STROBE_N;
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("fetch strobe phase");
  property p_fetch_in_data;
    O_CYC_BUSY && dat_ff |-> O_PROGRAM_FETCH_STROBE_N;
  endproperty
  a_fetch_in_data: assert property (p_fetch_in_data)
    else $error("fetch strobe in data move");
  property p_stretch_out;
    O_STRETCH_SELECT == $past(st_ff);
  endproperty
  a_stretch_out: assert property (p_stretch_out)
    else $error("stretch select wrong");
  property p_len;
    $fell(O_CYC_BUSY) |-> len_ff == exp_ff;
  endproperty
  a_len: assert property (p_len)
    else $error("cycle length");
  property p_rdwr;
    !(O_P3_PULL_DOWN[6] && O_P3_PULL_DOWN[7]);
  endproperty
  a_rdwr: assert property (p_rdwr)
    else $error("read and write strobes together");
  property p_boost;
    (|O_P1_STRONG_UP || |O_P3_STRONG_UP) |=> O_P1_STRONG_UP == 8'h00 && O_P3_STRONG_UP == 8'h00;
  endproperty
  a_boost: assert property (p_boost)
    else $error("boost too long");
  property p_irq;
    $rose(I_P1_PINS[6]) |-> ##[1:3] O_EXT_IRQ_EDGE[2];
  endproperty
  a_irq: assert property (p_irq)
    else $error("rising edge missed");
endmodule // mbp_bus_pins_chk
bind mbp_bus_pins mbp_bus_pins_chk u_chk (.*);

// >>> mbp_ext_mem.sv
// Purpose: External ROM, RAM and address latch on the bus
// Assumes: Strobes seen through the pin pulldown enables
// Notes:   Released bus shows a changing pattern, not held data
`timescale 1ns/1ps
module mbp_ext_mem (
  input  wire       clk,
  input  wire [7:0] bus_out,
  input  wire       bus_oe,
  input  wire       ale,
  input  wire [7:0] hi,
  input  wire       fetch_n,
  input  wire       wr_pd,
  input  wire       rd_pd,
  output logic [7:0] bus_in
);
  logic [7:0]  lo_q = 8'h00;
  logic [7:0]  last_q = 8'h00;
  logic [7:0]  ram [0:65535];
  wire  [15:0] adr = {hi, lo_q};
  always @(posedge clk) begin
    if (ale && bus_oe)
      lo_q <= bus_out;
    if (wr_pd && bus_oe)
      ram[adr] <= bus_out;
    last_q <= bus_in;
  end
  always @* begin
    if (bus_oe)
      bus_in = bus_out;
    else if (!fetch_n)
      bus_in = adr[7:0] ^ adr[15:8] ^ 8'hA5;
    else if (rd_pd)
      bus_in = ram[adr];
    else
      bus_in = ~last_q;
  end
endmodule // mbp_ext_mem

// >>> mbp_bus_pins_tb_top.sv
// Purpose: Self-checking bench for the bus and pin block
// Assumes: Inputs change by non-blocking assignment at rising edges
// Notes:   Expected read data is queued and matched on each done
`timescale 1ns/1ps
module mbp_bus_pins_tb_top;
  logic        I_REF_CLK = 1'b0;
  logic        I_RST_N = 1'b0;
  logic        I_RESET_PIN = 1'b0;
  logic        I_CYC_START = 1'b0;
  logic        I_CYC_IS_DATA = 1'b0;
  logic        I_CYC_IS_WRITE = 1'b0;
  logic        I_CYC_USE_P2_LATCH = 1'b0;
  logic [15:0] I_CYC_ADDR = 16'h0000;
  logic [7:0]  I_CYC_WDATA = 8'h00;
  logic        I_STRETCH_WR = 1'b0;
  logic [2:0]  I_STRETCH_DATA = 3'h0;
  logic        I_P1_WR = 1'b0, I_P2_WR = 1'b0, I_P3_WR = 1'b0;
  logic [7:0]  I_P1_WDATA = 8'hFF, I_P2_WDATA = 8'hFF, I_P3_WDATA = 8'hFF, I_P1_PINS = 8'hFF;
  logic        I_SERIAL0_TRANSMIT_OUT = 1'b1, I_TIMER2_EXT_IO_OUT = 1'b1;
  wire  [7:0]  I_MUXED_LOW_ADDR_DATA, O_MUXED_LOW_ADDR_DATA, O_HIGH_ADDR, O_CYC_RDATA;
  wire  [7:0]  O_P1_PULL_DOWN, O_P1_STRONG_UP, O_P3_PULL_DOWN, O_P3_STRONG_UP;
  wire         O_MUXED_LOW_ADDR_DATA_OE, O_ADDR_LATCH_PULSE, O_PROGRAM_FETCH_STROBE_N, O_CYC_DONE, O_CYC_BUSY;
  wire  [2:0]  O_STRETCH_SELECT;
  wire  [3:0]  O_EXT_IRQ_EDGE;
  wire  [7:0]  O_P1_IN, O_P3_IN;
  wire         O_CONFIG_FAULT;
  wire  [7:0]  I_P3_PINS = ~O_P3_PULL_DOWN;
  wire  [5:0]  rvec = {O_ADDR_LATCH_PULSE, O_PROGRAM_FETCH_STROBE_N, O_MUXED_LOW_ADDR_DATA_OE, O_STRETCH_SELECT};
  logic [8:0]  expq [$];
  logic [8:0]  e;
  logic [7:0]  v, o1, o3, d, h;
  logic [15:0] a, su;
  logic [3:0]  ev;
  int          n_fail = 0;
  int          num_checks = 0;
  int          cur_s = 1;
  int          ticks = 0;

  always #50 I_REF_CLK = ~I_REF_CLK;

  mbp_bus_pins u_dut (
    .I_EXT_FETCH_SELECT(1'b0),
    .*
  );
  mbp_ext_mem u_mem (
    .clk(I_REF_CLK), .bus_out(O_MUXED_LOW_ADDR_DATA), .bus_oe(O_MUXED_LOW_ADDR_DATA_OE),
    .ale(O_ADDR_LATCH_PULSE), .hi(O_HIGH_ADDR), .fetch_n(O_PROGRAM_FETCH_STROBE_N),
    .wr_pd(O_P3_PULL_DOWN[6]), .rd_pd(O_P3_PULL_DOWN[7]), .bus_in(I_MUXED_LOW_ADDR_DATA)
  );

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Mode is {data, write}; rf adds a start while busy that must be ignored
  task automatic cyc(input logic [1:0] m, input logic [15:0] ad, input logic [7:0] wd, input logic [7:0] ex,
                     input logic rf);
    int n;
    n = 0;
    I_CYC_START <= 1'b1;
    I_CYC_IS_DATA <= m[1];
    I_CYC_IS_WRITE <= m[0];
    I_CYC_ADDR <= ad;
    I_CYC_WDATA <= wd;
    expq.push_back({~m[0], ex});
    @(posedge I_REF_CLK);
    I_CYC_START <= 1'b0;
    do begin
      @(posedge I_REF_CLK);
      n++;
      if (rf && n inside {2, 3})
        I_CYC_START <= (n == 2);
    end while (O_CYC_DONE !== 1'b1 && n < 60);
    chk(n, m[1] ? 4 * (2 + cur_s) + 1 : 4 + 1, "cycle length");
  endtask

  always @(posedge I_REF_CLK) begin
    if (O_CYC_DONE === 1'b1) begin
      if (expq.size() == 0)
        chk(1, 0, "spurious done");
      else begin
        e = expq.pop_front();
        if (e[8])
          chk(O_CYC_RDATA, e[7:0], "read data");
      end
    end
  end

  always @(posedge I_REF_CLK) begin
    ticks++;
    if (ticks == 3000) begin
      n_fail++;
      results();
    end
  end

  initial begin
    void'($urandom(21));
    repeat (20) @(posedge I_REF_CLK);
    chk(rvec, 6'h31, "reset pins");
    I_RST_N <= 1'b1;
    o1 = 8'hFF;
    o3 = 8'hFF;
    // P3 strobe and transmit bits stay high so the bus strobes remain exclusive
    for (int i = 0; i < 6; i++) begin
      v = i[0] ? ~o1 : 8'($urandom);
      I_P1_WR <= 1'b1;
      I_P1_WDATA <= v;
      I_P3_WR <= 1'b1;
      I_P3_WDATA <= v | 8'hC2;
      @(posedge I_REF_CLK);
      I_P1_WR <= 1'b0;
      I_P3_WR <= 1'b0;
      su = 16'h0000;
      repeat (4) begin
        @(posedge I_REF_CLK);
        su = su | {O_P1_STRONG_UP, O_P3_STRONG_UP};
      end
      chk({O_P1_PULL_DOWN, O_P3_PULL_DOWN}, {~v, ~(v | 8'hC2)}, "pulldown");
      chk(su, {~o1 & v, ~o3 & (v | 8'hC2)}, "boost");
      o1 = v;
      o3 = v | 8'hC2;
    end
    I_P1_WR <= 1'b1;
    I_P1_WDATA <= 8'hFF;
    I_SERIAL0_TRANSMIT_OUT <= 1'b0;
    I_TIMER2_EXT_IO_OUT <= 1'b0;
    @(posedge I_REF_CLK);
    I_P1_WR <= 1'b0;
    repeat (2) @(posedge I_REF_CLK);
    chk({O_P1_PULL_DOWN, O_P3_PULL_DOWN, O_CONFIG_FAULT}, {8'h01, ~o3 | 8'h02, 1'b0}, "alt pulldown");
    I_SERIAL0_TRANSMIT_OUT <= 1'b1;
    I_TIMER2_EXT_IO_OUT <= 1'b1;
    for (int s = 0; s < 8; s++) begin
      I_STRETCH_WR <= 1'b1;
      I_STRETCH_DATA <= 3'(s);
      @(posedge I_REF_CLK);
      I_STRETCH_WR <= 1'b0;
      cur_s = s;
      a = 16'($urandom);
      d = 8'($urandom);
      cyc(2'b11, a, d, 8'h00, s == 3);
      cyc(2'b10, a, 8'h00, d, 1'b0);
      cyc(2'b00, a, 8'h00, a[7:0] ^ a[15:8] ^ 8'hA5, 1'b0);
    end
    h = 8'($urandom);
    I_P2_WR <= 1'b1;
    I_P2_WDATA <= h;
    @(posedge I_REF_CLK);
    I_P2_WR <= 1'b0;
    cyc(2'b11, {h, a[7:0]}, d, 8'h00, 1'b0);
    I_CYC_USE_P2_LATCH <= 1'b1;
    cyc(2'b10, {~h, a[7:0]}, 8'h00, d, 1'b0);
    cyc(2'b00, {~h, a[7:0]}, 8'h00, a[7:0] ^ ~h ^ 8'hA5, 1'b0);
    I_CYC_USE_P2_LATCH <= 1'b0;
    for (int j = 0; j < 2; j++) begin
      I_P1_PINS <= j ? 8'hFF : 8'h0F;
      ev = 4'h0;
      repeat (5) begin
        @(posedge I_REF_CLK);
        ev = ev | O_EXT_IRQ_EDGE;
      end
      chk(ev, j ? 4'h5 : 4'hA, "edge events");
      chk({O_P1_IN, O_P3_IN}, {j ? 8'hFF : 8'h0F, o3}, "pin inputs");
    end
    I_RESET_PIN <= 1'b1;
    repeat (2) @(posedge I_REF_CLK);
    chk(rvec, 6'h31, "reset pin");
    I_RESET_PIN <= 1'b0;
    cur_s = 1;
    @(posedge I_REF_CLK);
    cyc(2'b10, {h, a[7:0]}, 8'h00, d, 1'b0);
    @(posedge I_REF_CLK);
    results();
  end
endmodule // mbp_bus_pins_tb_top
